// file: hdl/upc_control_port.sv
// Control port of a USB transceiver: mode pins, power state, line state
// report, interface clock and upper-byte valid, with a Wishbone slave.
// Assumes mode pins and line pins arrive asynchronously; the receive
// datapath inputs share clk.
// Functional notes
// - A high synchronous reset returns every state machine to its start.
// - Speed select 0 enables the high-speed, 1 the full-speed transceiver.
// - Termination select 0 gives high-speed, 1 full-speed termination.
// - Suspend input low powers down all but suspend and resume logic.
// - The device drives an interface clock whose rising edge times data.
// - Mode 0 normal, 1 non-driving, 2 no stuffing and NRZI, 3 reserved.
// - Line state bit 0 follows the positive line, bit 1 the negative line.
// - Line state is registered in normal use, combinational when suspended; here also combinational while resuming.
// - Width select 0 gives an 8-bit byte clock path, 1 a 16-bit word path.
// - In 16-bit mode upper-byte valid marks whether the high byte is valid.
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/100ps
module upc_control_port #(
   parameter int          RESUME_CYCLES = upc_pkg::RESUME_CYCLES,
   parameter logic [15:0] BYTE_INC      = upc_pkg::BYTE_INC_RST,
   parameter logic [15:0] WORD_INC      = upc_pkg::WORD_INC_RST
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output      logic [31:0] wb_dat_o,
   output      logic        wb_ack_o,
   // Controller mode pins
   input  wire logic        speedTransceiverChoice,
   input  wire logic        terminationChoice,
   input  wire logic        lowPowerRequestN,
   input  wire logic [1:0]  operatingModeSelect,
   input  wire logic        pathWidthSelect,
   input  wire logic        txValid,
   // Upper-byte valid, two-way pin
   input  wire logic        upperByteValidIn,
   output      logic        upperByteValidOut,
   output      logic        upperByteValidOe,
   // USB line levels
   input  wire logic        usbPositiveLine,
   input  wire logic        usbNegativeLine,
   // Receive datapath, same clock
   input  wire logic        rxValid,
   input  wire logic        rxHighValid,
   // Outputs to the controller
   output      logic        interfaceClockOut,
   output      logic [1:0]  lineState,
   // Outputs to the analog and serial logic
   output      logic        hsXcvrEnable,
   output      logic        fsXcvrEnable,
   output      logic        hsTermEnable,
   output      logic        fsPullupEnable,
   output      logic        lineDriveEnable,
   output      logic        bitStuffEnable,
   output      logic        nrziEnable,
   output      logic        powerDown,
   output      logic        wordPath,
   output      logic        txHighValid
);
   typedef struct packed {
      upc_pkg::upc_power_t           pwr;
      logic [upc_pkg::RESUME_W-1:0]  resumeCnt;
      logic [upc_pkg::PHASE_W-1:0]   phase;
      logic [31:0]                   rate;
      logic [31:0]                   rdata;
      logic                          ack;
      logic [1:0]                    line;
      logic                          hsX;
      logic                          fsX;
      logic                          hsT;
      logic                          fsP;
      logic                          drive;
      logic                          stuff;
      logic                          nrzi;
      logic                          pd;
      logic                          word;
      logic                          ubvOut;
      logic                          ubvOe;
      logic                          txHigh;
   } upc_state_t;

   localparam logic [upc_pkg::RESUME_W-1:0] RESUME_LAST =
      upc_pkg::RESUME_W'(RESUME_CYCLES - 1);

   upc_state_t s;
   upc_state_t next_s;
   logic [upc_pkg::PIN_W-1:0] pins;
   logic [upc_pkg::PIN_W-1:0] pinsAsync;
   logic [1:0]                mode;
   logic                      suspendPin;
   logic                      busHit;
   logic [upc_pkg::PHASE_W-1:0] inc;
   logic [31:0]               status;

   assign pinsAsync = {upperByteValidIn, txValid, usbNegativeLine,
                       usbPositiveLine, pathWidthSelect, operatingModeSelect,
                       lowPowerRequestN, terminationChoice,
                       speedTransceiverChoice};

   upc_sync #(
      .WIDTH (upc_pkg::PIN_W),
      .RST   (upc_pkg::PIN_RST)
   ) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .async   (pinsAsync),
      .synced  (pins)
   );

   assign mode = pins[upc_pkg::PIN_MODE_HI:upc_pkg::PIN_MODE_LO];
   assign suspendPin = !pins[upc_pkg::PIN_SUSP_N];
   assign busHit = wb_cyc_i && wb_stb_i && !s.ack;
   // Accumulator MSB toggles at inc/2^16 of clk; not capped, aliases above half of clk
   assign inc = (pins[upc_pkg::PIN_WIDTH] == upc_pkg::WIDTH_16) ?
                s.rate[31:16] : s.rate[15:0];

   always_comb begin
      status = 32'h0000_0000;
      // Synced copy: raw line pins must not reach the read data flops
      status[upc_pkg::ST_LINE_LO +: 2] = s.line;
      status[upc_pkg::ST_MODE_LO +: 2] = mode;
      status[upc_pkg::ST_SPEED] = pins[upc_pkg::PIN_SPEED];
      status[upc_pkg::ST_TERM] = pins[upc_pkg::PIN_TERM];
      status[upc_pkg::ST_WIDTH] = pins[upc_pkg::PIN_WIDTH];
      status[upc_pkg::ST_SUSP] = (s.pwr == upc_pkg::UPC_SUSPEND);
      status[upc_pkg::ST_RESUME] = (s.pwr == upc_pkg::UPC_RESUME);
   end

   always_comb begin
      next_s = s;
      case (s.pwr)
         upc_pkg::UPC_RUN: begin
            if (suspendPin) begin
               next_s.pwr = upc_pkg::UPC_SUSPEND;
            end
         end
         upc_pkg::UPC_SUSPEND: begin
            if (!suspendPin) begin
               next_s.pwr = upc_pkg::UPC_RESUME;
               next_s.resumeCnt = '0;
            end
         end
         upc_pkg::UPC_RESUME: begin
            if (suspendPin) begin
               next_s.pwr = upc_pkg::UPC_SUSPEND;
            end else if (s.resumeCnt == RESUME_LAST) begin
               next_s.pwr = upc_pkg::UPC_RUN;
            end else begin
               next_s.resumeCnt = s.resumeCnt + 1'b1;
            end
         end
         default: begin
            next_s.pwr = upc_pkg::UPC_RUN;
         end
      endcase
      next_s.pd = (next_s.pwr == upc_pkg::UPC_SUSPEND);

      // interface clock, stopped while powered down
      if (next_s.pd) begin
         next_s.phase = '0;
      end else begin
         next_s.phase = s.phase + inc;
      end

      next_s.line = {pins[upc_pkg::PIN_DM], pins[upc_pkg::PIN_DP]};

      next_s.hsX = !next_s.pd &&
                   (pins[upc_pkg::PIN_SPEED] == upc_pkg::SEL_HS);
      next_s.fsX = !next_s.pd &&
                   (pins[upc_pkg::PIN_SPEED] == upc_pkg::SEL_FS);
      // termination select, kept through suspend for the pull-up
      next_s.hsT = !next_s.pd &&
                   (pins[upc_pkg::PIN_TERM] == upc_pkg::SEL_HS);
      next_s.fsP = (pins[upc_pkg::PIN_TERM] == upc_pkg::SEL_FS);
      next_s.drive = !next_s.pd;
      next_s.stuff = 1'b1;
      next_s.nrzi = 1'b1;
      case (mode)
         upc_pkg::MODE_NORMAL: begin
         end
         upc_pkg::MODE_NODRIVE: begin
            next_s.hsT = 1'b0;
            next_s.fsP = 1'b0;
            next_s.drive = 1'b0;
         end
         upc_pkg::MODE_RAW: begin
            next_s.stuff = 1'b0;
            next_s.nrzi = 1'b0;
         end
         default: begin
            // Reserved: parked non-driving, the least harmful choice
            next_s.hsT = 1'b0;
            next_s.fsP = 1'b0;
            next_s.drive = 1'b0;
         end
      endcase

      next_s.word = (pins[upc_pkg::PIN_WIDTH] == upc_pkg::WIDTH_16);
      next_s.ubvOe = next_s.word && rxValid && !pins[upc_pkg::PIN_TXVAL];
      next_s.ubvOut = next_s.ubvOe && rxHighValid;
      next_s.txHigh = next_s.word && pins[upc_pkg::PIN_TXVAL] &&
                      pins[upc_pkg::PIN_TXHIGH];

      // Wishbone slave: one wait state, unmapped reads zero
      next_s.ack = busHit;
      next_s.rdata = 32'h0000_0000;
      if (busHit) begin
         case (wb_adr_i[upc_pkg::ADR_MSB:upc_pkg::ADR_LSB])
            upc_pkg::REG_STATUS[upc_pkg::ADR_MSB:upc_pkg::ADR_LSB]: begin
               next_s.rdata = status;
            end
            upc_pkg::REG_RATE[upc_pkg::ADR_MSB:upc_pkg::ADR_LSB]: begin
               next_s.rdata = s.rate;
               if (wb_we_i) begin
                  for (int i = 0; i < 4; i++) begin
                     if (wb_sel_i[i]) begin
                        next_s.rate[i*8 +: 8] = wb_dat_i[i*8 +: 8];
                     end
                  end
               end
            end
            default: begin
               next_s.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s <= '0;
         s.pwr <= upc_pkg::UPC_RUN;
         s.rate <= {WORD_INC, BYTE_INC};
         s.stuff <= 1'b1;
         s.nrzi <= 1'b1;
         s.fsP <= 1'b1;
         s.line <= upc_pkg::LINE_SE0;
      end else begin
         s <= next_s;
      end
   end

   // combinational line state while suspended or resuming
   assign lineState = (s.pwr == upc_pkg::UPC_RUN) ? s.line :
                      {usbNegativeLine, usbPositiveLine};
   assign interfaceClockOut = s.phase[upc_pkg::PHASE_W-1];
   assign wb_dat_o = s.rdata;
   assign wb_ack_o = s.ack;
   assign hsXcvrEnable = s.hsX;
   assign fsXcvrEnable = s.fsX;
   assign hsTermEnable = s.hsT;
   assign fsPullupEnable = s.fsP;
   assign lineDriveEnable = s.drive;
   assign bitStuffEnable = s.stuff;
   assign nrziEnable = s.nrzi;
   assign powerDown = s.pd;
   assign wordPath = s.word;
   assign upperByteValidOut = s.ubvOut;
   assign upperByteValidOe = s.ubvOe;
   assign txHighValid = s.txHigh;
endmodule

// file: hdl/upc_pkg.sv
// Constants for the transceiver control port: register map, pin bundle
// layout, line and mode encodings, reset values.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone bus.
package upc_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_RATE   = 8'h04;
   // Register index field of the Wishbone address
   localparam int ADR_MSB = 7;
   localparam int ADR_LSB = 2;
   // Synchronised pin bundle layout
   localparam int PIN_W       = 10;
   localparam int PIN_SPEED   = 0;
   localparam int PIN_TERM    = 1;
   localparam int PIN_SUSP_N  = 2;
   localparam int PIN_MODE_LO = 3;
   localparam int PIN_MODE_HI = 4;
   localparam int PIN_WIDTH   = 5;
   localparam int PIN_DP      = 6;
   localparam int PIN_DM      = 7;
   localparam int PIN_TXVAL   = 8;
   localparam int PIN_TXHIGH  = 9;
   // Suspend input comes out of reset inactive (not suspended)
   localparam logic [9:0] PIN_RST = 10'h004;
   // Speed and termination encodings
   localparam logic SEL_HS = 1'b0;
   localparam logic SEL_FS = 1'b1;
   // Path width encodings
   localparam logic WIDTH_8  = 1'b0;
   localparam logic WIDTH_16 = 1'b1;
   // Operating modes
   localparam logic [1:0] MODE_NORMAL   = 2'h0;
   localparam logic [1:0] MODE_NODRIVE  = 2'h1;
   localparam logic [1:0] MODE_RAW      = 2'h2;
   localparam logic [1:0] MODE_RESERVED = 2'h3;
   // Line state codes
   localparam logic [1:0] LINE_SE0 = 2'h0;
   localparam logic [1:0] LINE_J   = 2'h1;
   localparam logic [1:0] LINE_K   = 2'h2;
   localparam logic [1:0] LINE_SE1 = 2'h3;
   // Clock generator: phase accumulator width and default increments
   localparam int PHASE_W = 16;
   localparam logic [15:0] BYTE_INC_RST = 16'h7FFF;
   localparam logic [15:0] WORD_INC_RST = 16'h4000;
   // Resume settling
   localparam int RESUME_W = 16;
   localparam int RESUME_CYCLES = 16;
   // Status register fields
   localparam int ST_LINE_LO = 0;
   localparam int ST_MODE_LO = 2;
   localparam int ST_SPEED   = 4;
   localparam int ST_TERM    = 5;
   localparam int ST_WIDTH   = 6;
   localparam int ST_SUSP    = 7;
   localparam int ST_RESUME  = 8;
   // Power states, one-hot
   typedef enum logic [2:0] {
      UPC_RUN     = 3'b001,
      UPC_SUSPEND = 3'b010,
      UPC_RESUME  = 3'b100
   } upc_power_t;
endpackage

// file: hdl/upc_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pin inputs.
// Assumes each bit is a slow level; no bus coherency across bits.
`timescale 1ns/100ps
module upc_sync #(
   parameter int             WIDTH = 1,
   parameter logic [WIDTH-1:0] RST = '0
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async,
   output      logic [WIDTH-1:0] synced
);
   typedef struct packed {
      logic [WIDTH-1:0] first;
      logic [WIDTH-1:0] second;
   } upc_sync_t;

   upc_sync_t s;
   upc_sync_t next_s;

   always_comb begin
      next_s = s;
      next_s.first = async;
      next_s.second = s.first;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s <= {RST, RST};
      end else begin
         s <= next_s;
      end
   end

   assign synced = s.second;
endmodule

// file: test/upc_control_port_monitor.sv
// Assertion checker for the transceiver control port.
// Assumes it is bound to upc_control_port and sees only its ports.
`timescale 1ns/100ps
module upc_control_port_monitor (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        wb_ack_o,
   input wire logic        speedTransceiverChoice,
   input wire logic        terminationChoice,
   input wire logic        lowPowerRequestN,
   input wire logic [1:0]  operatingModeSelect,
   input wire logic        usbPositiveLine,
   input wire logic        usbNegativeLine,
   input wire logic        rxValid,
   input wire logic        rxHighValid,
   input wire logic        upperByteValidOut,
   input wire logic        upperByteValidOe,
   input wire logic        hsXcvrEnable,
   input wire logic        fsXcvrEnable,
   input wire logic        hsTermEnable,
   input wire logic        powerDown,
   input wire logic [1:0]  lineState
);
   logic [4:0] runCnt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Long awake stretch, so resume and sync latency are long past
   always_ff @(posedge clk) begin
      if (sys_rst || !lowPowerRequestN) runCnt <= 5'h00;
      else if (runCnt != 5'h1F) runCnt <= runCnt + 5'h01;
   end
   AST_HS_XCVR: assert property (hsXcvrEnable |->
      !$past(speedTransceiverChoice, 3)) else $error("hs xcvr wrong");
   AST_FS_XCVR: assert property (fsXcvrEnable |->
      $past(speedTransceiverChoice, 3) && !hsXcvrEnable)
      else $error("fs xcvr wrong");
   AST_HS_TERM: assert property (hsTermEnable |->
      !$past(terminationChoice, 3) && !$past(operatingModeSelect[0], 3))
      else $error("hs termination wrong");
   AST_SUSPEND: assert property (powerDown |->
      !hsXcvrEnable && !fsXcvrEnable && !hsTermEnable)
      else $error("function alive in suspend");
   AST_LINE_COMB: assert property (powerDown |->
      lineState == {usbNegativeLine, usbPositiveLine})
      else $error("line state not direct in suspend");
   AST_LINE_SYNC: assert property (runCnt == 5'h1F |->
      lineState == $past({usbNegativeLine, usbPositiveLine}, 3))
      else $error("line state not registered");
   AST_UBV_OE: assert property (upperByteValidOe |->
      $past(rxValid)) else $error("upper valid driven without rx");
   AST_UBV_OUT: assert property (upperByteValidOut |->
      upperByteValidOe && $past(rxHighValid))
      else $error("upper valid high wrongly");
   COV_ACK: cover property (wb_ack_o);
   COV_SUSP: cover property (powerDown);
   COV_UBV: cover property (upperByteValidOut);
endmodule

// file: test/upc_ctrl_model.sv
// Behavioural device controller driving the mode pins.
// Assumes the bench gives requests; pins change right after clk edges.
`timescale 1ns/100ps
module upc_ctrl_model (
   input  wire logic       clk,
   input  wire logic       reqSpeed,
   input  wire logic       reqTerm,
   input  wire logic       reqSusN,
   input  wire logic [1:0] reqMode,
   input  wire logic       reqWidth,
   input  wire logic       reqTx,
   input  wire logic       reqHigh,
   output logic            speedTransceiverChoice,
   output logic            terminationChoice,
   output logic            lowPowerRequestN,
   output logic [1:0]      operatingModeSelect,
   output logic            pathWidthSelect,
   output logic            txValid,
   output logic            ctrlUbv
);
   initial begin
      {speedTransceiverChoice, terminationChoice, pathWidthSelect} = 3'h0;
      {lowPowerRequestN, txValid, ctrlUbv} = 3'h4;
      operatingModeSelect = 2'h0;
   end
   always @(posedge clk) begin
      speedTransceiverChoice <= reqSpeed;
      pathWidthSelect <= reqWidth;
      terminationChoice <= reqSusN ? reqTerm : upc_pkg::SEL_FS;
      lowPowerRequestN <= reqSusN;
      operatingModeSelect <= (reqMode == upc_pkg::MODE_RESERVED) ?
         upc_pkg::MODE_NORMAL : reqMode;
      txValid <= reqTx;
      // pin driven only while sending; else it wanders
      ctrlUbv <= reqTx ? reqHigh : ~ctrlUbv;
   end
endmodule

// file: test/upc_control_port_tb.sv
// Self-checking bench for the transceiver control port.
// Assumes a 100 MHz clk; mode pins come from the controller model, line pins from the bench.
`timescale 1ns/100ps
module upc_control_port_tb;
   logic clk = 1'b0, sys_rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0, usbPositiveLine = 1'b0, usbNegativeLine = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
   logic rxValid = 1'b0, rxHighValid = 1'b0, reqSpeed = 1'b0, reqTerm = 1'b0;
   logic reqSusN = 1'b1, reqWidth = 1'b0, reqTx = 1'b0, reqHigh = 1'b0;
   logic [1:0] reqMode = 2'h0, operatingModeSelect, lineState;
   logic wb_ack_o, speedTransceiverChoice, terminationChoice, ctrlUbv;
   logic lowPowerRequestN, pathWidthSelect, txValid, upperByteValidOut;
   logic upperByteValidOe, interfaceClockOut, hsXcvrEnable, fsXcvrEnable;
   logic hsTermEnable, fsPullupEnable, lineDriveEnable, bitStuffEnable;
   logic nrziEnable, powerDown, wordPath, txHighValid, upperByteValidIn;
   logic [7:0] outs;
   logic [12:0] rows [4] = '{13'h00AE, 13'h195F, 13'h0A86, 13'h1569};
   int failures = 0, checks_done = 0, cycles = 0, n;
   assign upperByteValidIn = upperByteValidOe ? upperByteValidOut : ctrlUbv;
   assign outs = {hsXcvrEnable, fsXcvrEnable, hsTermEnable, fsPullupEnable,
      lineDriveEnable, bitStuffEnable, nrziEnable, wordPath};
   upc_control_port #(.RESUME_CYCLES(2)) uut (.*);
   upc_ctrl_model partner (.*);
   always #5 clk = ~clk;
   task automatic stop_test;
      $display("Checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Classic cycle held until ack is sampled high at an edge
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [3:0] s, input logic [31:0] d);
      @(posedge clk);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
      {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
      // Only the bench timeout ends a wait for ack
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask
   // Rising edges of the interface clock over 32 cycles
   task automatic rises(output int r);
      logic last;
      r = 0;
      @(posedge clk);
      last = interfaceClockOut;
      repeat (32) begin
         @(posedge clk);
         if (interfaceClockOut && !last) r++;
         last = interfaceClockOut;
      end
   endtask
   always @(posedge clk) if (++cycles == 5000) begin
      failures++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      chk("reset outs", 32'h16, outs);
      chk("reset clock", 32'h0, interfaceClockOut);
      sys_rst <= 1'b0;
      foreach (rows[i]) begin
         {reqSpeed, reqTerm, reqMode, reqWidth} <= rows[i][12:8];
         repeat (6) @(posedge clk);
         chk("mode outs", rows[i][7:0], outs);
      end
      {reqSpeed, reqTerm, reqMode, reqWidth} <= 5'h18;
      {usbNegativeLine, usbPositiveLine} <= 2'h1;
      wb(1'b0, 8'h04, 4'hF, 32'h0);
      chk("rate reset", 32'h40007FFF, q);
      wb(1'b1, 8'h04, 4'h1, 32'hFFFFFF12);
      wb(1'b0, 8'h04, 4'hF, 32'h0);
      chk("rate lane", 32'h40007F12, q);
      wb(1'b1, 8'h04, 4'hF, 32'h40008000);
      wb(1'b1, 8'h00, 4'hF, 32'hFFFFFFFF);
      wb(1'b0, 8'h00, 4'hF, 32'h0);
      chk("status", 32'h031, q & 32'h1FF);
      wb(1'b0, 8'h40, 4'hF, 32'h0);
      chk("unmapped", 32'h0, q);
      rises(n);
      chk("byte clock", 32'd16, n);
      reqWidth <= 1'b1;
      repeat (6) @(posedge clk);
      rises(n);
      chk("word clock", 32'd8, n);
      {rxValid, rxHighValid} <= 2'h3;
      repeat (6) @(posedge clk);
      chk("rx upper", 32'h6, {upperByteValidOe, upperByteValidOut,
         txHighValid});
      {rxValid, reqTx, reqHigh} <= 3'h3;
      repeat (6) @(posedge clk);
      chk("tx upper", 32'h1, {upperByteValidOe, upperByteValidOut,
         txHighValid});
      {reqTx, reqWidth} <= 2'h0;
      for (int c = 0; c < 4; c++) begin
         {usbNegativeLine, usbPositiveLine} <= c[1:0];
         repeat (5) @(posedge clk);
         chk("line run", c, lineState);
      end
      {reqSusN, reqTerm} <= 2'h0;
      repeat (8) @(posedge clk);
      chk("suspend", 32'h1, {powerDown, fsPullupEnable} == 2'h3);
      {usbNegativeLine, usbPositiveLine} <= 2'h2;
      #1 chk("line direct", 32'h2, lineState);
      @(posedge clk);
      reqSusN <= 1'b1;
      repeat (12) @(posedge clk);
      chk("resumed", 32'h0, powerDown);
      stop_test();
   end
endmodule
bind upc_control_port upc_control_port_monitor mon (.*);
